// file: core/adc_cycle_serial_readout.sv
// Converter cycle control with a three-wire serial result readout.
// Assumes a 20 MHz clk, an external result source on clk, and the
// serial clock pin level fed back on link_sck as its own clock domain.
`default_nettype none
`include "adc_readout_map.svh"

module adc_cycle_serial_readout
  import adc_readout_pkg::*;
#(
  parameter int POR_CYCLES = `POR_CYCLES,
  parameter int CONV_CYCLES = `CONV_CYCLES_DEFAULT
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic link_sck,
  input wire logic cs_n_pin,
  input wire logic signed [`RAW_BITS-1:0] raw_result,
  output logic serial_out_pin,
  output logic serial_out_oe,
  output logic sck_out,
  output logic sck_oe,
  output logic converting,
  output logic sleeping,
  output logic int_sck_mode
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Clamp raw value and convert to offset-binary code
  function automatic code_t encode_result(input logic signed [`RAW_BITS-1:0] raw);
    logic signed [`RAW_BITS-1:0] lim;
    logic [`RAW_BITS-1:0] sum;
    lim = raw;
    if (raw > `RAW_MAX) begin
      lim = `RAW_MAX;
    end else if (raw < `RAW_MIN) begin
      lim = `RAW_MIN;
    end
    sum = lim + `CODE_OFFSET;
    return sum[`CODE_BITS-1:0];
  endfunction

  // Frame bit sent after a given count of falling edges
  function automatic logic frame_bit_after(input frame_t f, input logic [4:0] cnt);
    logic [4:0] idx;
    idx = 5'h16 - cnt;
    if (cnt >= `LAST_SHIFT_IDX) begin
      return 1'b1;
    end
    return f[idx];
  endfunction

  // ****************************************************************
  // Declarations
  // ****************************************************************
  conv_state_t state_reg;
  logic [16:0] por_cnt_reg;
  logic [31:0] conv_cnt_reg;
  frame_t frame_reg;
  logic eoc_reg;
  logic out_sel_reg;
  logic started_reg;
  logic cs_sync1_reg;
  logic cs_sync2_reg;
  logic cs_prev_reg;
  logic sck_sync1_reg;
  logic sck_sync2_reg;
  logic rise_sync1_reg;
  logic rise_sync2_reg;
  logic done_sync1_reg;
  logic done_sync2_reg;
  logic done_prev_reg;
  logic [15:0] isck_div_reg;
  logic [5:0] isck_tog_reg;
  logic rise_seen_reg;
  logic [4:0] fall_cnt_reg;
  logic shift_bit_reg;
  logic end_seen_reg;
  logic fresh_rise;
  logic cs_fall;
  logic cs_high;
  logic frame_done;

  assign cs_high = cs_sync2_reg;
  assign cs_fall = cs_prev_reg & ~cs_sync2_reg;
  assign frame_done = done_sync2_reg & ~done_prev_reg;

  // A rise counts only while the link holds no finished frame; with select
  // kept low past frame end the link flops stay stale until select rises
  assign fresh_rise = rise_sync2_reg & ~done_sync2_reg;

  // ****************************************************************
  // Pin and cross-domain synchronisers
  // ****************************************************************

  // Select and clock pin levels into clk
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_sync1_reg <= 1'b1;
      cs_sync2_reg <= 1'b1;
      cs_prev_reg <= 1'b1;
      sck_sync1_reg <= 1'b0;
      sck_sync2_reg <= 1'b0;
    end else begin
      cs_sync1_reg <= cs_n_pin;
      cs_sync2_reg <= cs_sync1_reg;
      cs_prev_reg <= cs_sync2_reg;
      sck_sync1_reg <= link_sck;
      sck_sync2_reg <= sck_sync1_reg;
    end
  end

  // Link-side frame events into clk
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_sync1_reg <= 1'b0;
      rise_sync2_reg <= 1'b0;
      done_sync1_reg <= 1'b0;
      done_sync2_reg <= 1'b0;
      done_prev_reg <= 1'b0;
    end else begin
      rise_sync1_reg <= rise_seen_reg;
      rise_sync2_reg <= rise_sync1_reg;
      done_sync1_reg <= end_seen_reg; // Single flop crosses, no compare glitch
      done_sync2_reg <= done_sync1_reg;
      done_prev_reg <= done_sync2_reg;
    end
  end

  // ****************************************************************
  // Converter cycle
  // ****************************************************************

  // State sequence: reset, convert, sleep, output
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_POR;
    end else begin
      unique case (state_reg)
        ST_POR: begin
          if (por_cnt_reg == 17'(POR_CYCLES - 1)) begin
            state_reg <= ST_CONVERT;
          end
        end
        ST_CONVERT: begin
          if (conv_cnt_reg == 32'(CONV_CYCLES - 1)) begin
            state_reg <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (!cs_high) begin
            state_reg <= ST_OUTPUT;
          end
        end
        ST_OUTPUT: begin
          if (frame_done) begin
            state_reg <= ST_CONVERT;
          end else if (cs_high) begin
            state_reg <= (started_reg || fresh_rise) ? ST_CONVERT : ST_SLEEP;
          end
        end
        default: begin
          state_reg <= ST_POR;
        end
      endcase
    end
  end

  // Power-on reset timer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      por_cnt_reg <= 17'h00000;
    end else if (state_reg == ST_POR) begin
      por_cnt_reg <= por_cnt_reg + 17'h00001;
    end
  end

  // Conversion length counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_cnt_reg <= 32'h00000000;
    end else if (state_reg == ST_CONVERT) begin
      conv_cnt_reg <= conv_cnt_reg + 32'h00000001;
    end else begin
      conv_cnt_reg <= 32'h00000000;
    end
  end

  // Result frame, loaded once per conversion and held static
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_reg <= '0;
    end else if (state_reg == ST_CONVERT && conv_cnt_reg == 32'(CONV_CYCLES - 1)) begin
      frame_reg <= {1'b0, 1'b0, encode_result(raw_result), 4'h0};
    end
  end

  // Pending flag, high in power-on reset and while converting, set again at frame end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      eoc_reg <= 1'b1;
    end else if (state_reg == ST_CONVERT) begin
      eoc_reg <= (conv_cnt_reg != 32'(CONV_CYCLES - 1));
    end else if (state_reg == ST_OUTPUT && frame_done) begin
      eoc_reg <= 1'b1;
    end else begin
      eoc_reg <= (state_reg == ST_POR);
    end
  end

  // Remember that the first rising clock edge was seen
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      started_reg <= 1'b0;
    end else if (state_reg == ST_OUTPUT) begin
      started_reg <= started_reg | fresh_rise;
    end else begin
      started_reg <= 1'b0;
    end
  end

  // Clock direction strap at power-up and each select fall
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_sck_mode <= 1'b0;
    end else if ((state_reg == ST_POR && por_cnt_reg == 17'(POR_CYCLES - 1)) || cs_fall) begin
      int_sck_mode <= sck_sync2_reg;
    end
  end

  // ****************************************************************
  // Internal serial clock generator
  // ****************************************************************

  // 24 clock periods, starting low, only in output state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      isck_div_reg <= 16'h0000;
      isck_tog_reg <= 6'h00;
      sck_out <= 1'b0;
      sck_oe <= 1'b0;
    end else if (state_reg == ST_OUTPUT && int_sck_mode && !cs_high) begin
      sck_oe <= 1'b1;
      if (isck_tog_reg != `ISCK_TOGGLES) begin
        if (isck_div_reg == 16'(`ISCK_HALF_CYCLES - 1)) begin
          isck_div_reg <= 16'h0000;
          isck_tog_reg <= isck_tog_reg + 6'h01;
          sck_out <= ~sck_out;
        end else begin
          isck_div_reg <= isck_div_reg + 16'h0001;
        end
      end
    end else begin
      isck_div_reg <= 16'h0000;
      isck_tog_reg <= 6'h00;
      sck_out <= 1'b0;
      sck_oe <= 1'b0;
    end
  end

  // ****************************************************************
  // Pin-facing status
  // ****************************************************************

  // Output path, enable and state flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_sel_reg <= 1'b0;
      serial_out_oe <= 1'b0;
      converting <= 1'b0;
      sleeping <= 1'b0;
    end else begin
      out_sel_reg <= (state_reg == ST_OUTPUT) && !done_sync2_reg;
      serial_out_oe <= !cs_high;
      converting <= (state_reg == ST_CONVERT);
      sleeping <= (state_reg == ST_SLEEP);
    end
  end

  // Shift path during output, pending flag otherwise
  assign serial_out_pin = out_sel_reg ? shift_bit_reg : eoc_reg;

  // ****************************************************************
  // Link clock domain, held in reset while select is high
  // ****************************************************************

  // First rising edge of the frame
  always_ff @(posedge link_sck or posedge cs_n_pin) begin
    if (cs_n_pin) begin
      rise_seen_reg <= 1'b0;
    end else begin
      rise_seen_reg <= 1'b1;
    end
  end

  // Falling-edge shifter; frame_reg is static while output runs
  // Falls before the first rise are ignored, such as the pin handing over
  // from the pull-up level to the device's own low clock
  always_ff @(negedge link_sck or posedge cs_n_pin) begin
    if (cs_n_pin) begin
      fall_cnt_reg <= 5'h00;
      shift_bit_reg <= 1'b0;
      end_seen_reg <= 1'b0;
    end else if (rise_seen_reg) begin
      if (fall_cnt_reg != `FRAME_END_CNT) begin
        fall_cnt_reg <= fall_cnt_reg + 5'h01;
      end
      if (fall_cnt_reg == `LAST_SHIFT_IDX) begin
        end_seen_reg <= 1'b1;
      end
      shift_bit_reg <= frame_bit_after(frame_reg, fall_cnt_reg);
    end
  end

endmodule

`default_nettype wire

// file: pkg/adc_readout_map.svh
// Constants of the converter cycle and serial readout block.
// Assumes a 20 MHz system clock; included by the package and the core.
`ifndef ADC_READOUT_MAP_SVH
`define ADC_READOUT_MAP_SVH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define CLK_PERIOD_NS 50
`define POR_TIME_US 4000
`define POR_CYCLES ((`POR_TIME_US * 1000) / `CLK_PERIOD_NS)
`define CONV_CYCLES_DEFAULT 5000
`define ISCK_PERIOD_NS 26042
`define ISCK_HALF_CYCLES ((`ISCK_PERIOD_NS / 2) / `CLK_PERIOD_NS)

// ****************************************************************
// Frame layout
// ****************************************************************
`define FRAME_BITS 24
`define FRAME_PEND_BIT 23
`define FRAME_FILL_BIT 22
`define FRAME_CODE_MSB 21
`define FRAME_CODE_LSB 4
`define CODE_BITS 18
`define TAIL_BITS 4
`define LAST_SHIFT_IDX 5'h17
`define FRAME_END_CNT 5'h18
`define ISCK_TOGGLES 6'h30

// ****************************************************************
// Result coding
// ****************************************************************
`define RAW_BITS 19
`define RAW_MAX 19'sh10000
`define RAW_MIN (-19'sh10001)
`define CODE_OFFSET 19'h20000

`endif

// file: pkg/adc_readout_pkg.sv
// Types of the converter cycle and serial readout block.
// Assumes the constant header is found on the include path.
`default_nettype none
`include "adc_readout_map.svh"

package adc_readout_pkg;

  // Converter cycle states, one-hot
  typedef enum logic [3:0] {
    ST_POR     = 4'h1,
    ST_CONVERT = 4'h2,
    ST_SLEEP   = 4'h4,
    ST_OUTPUT  = 4'h8
  } conv_state_t;

  typedef logic [`FRAME_BITS-1:0] frame_t;
  typedef logic [`CODE_BITS-1:0] code_t;

endpackage

`default_nettype wire

// file: verification/adc_host_model.sv
// Host model: drives select and the external serial clock, reads data.
// Assumes the bench resolves the clock and data pins around it.
`default_nettype none
module adc_host_model (
  input wire logic clk,
  input wire logic sdo_pin,
  input wire logic sck_pin,
  output var logic cs_n,
  output var logic sck
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle: deselected, clock held low so the strap picks external mode
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
  end
  // One read: select, n periods of 64 ns, bit taken at each rise
  task automatic frame(input int n, input bit rel, output logic [31:0] bits);
    bits = '0;
    @(posedge clk) #2 cs_n = 1'b0;
    #300;
    repeat (n) begin
      bits = {bits[30:0], sdo_pin};
      sck = 1'b1;
      #32 sck = 1'b0;
      #32;
    end
    if (rel)
      @(posedge clk) #2 cs_n = 1'b1;
  endtask
  // Device-clocked read: clock high across select fall, bit taken at each rise
  task automatic frame_int(output logic [31:0] bits);
    bits = '0;
    @(posedge clk) #2 sck = 1'b1;
    @(posedge clk) #2 cs_n = 1'b0;
    #400 sck = 1'b0;
    repeat (24) begin
      @(posedge sck_pin);
      bits = {bits[30:0], sdo_pin};
    end
    @(negedge sck_pin);
    @(posedge clk) #2 cs_n = 1'b1;
  endtask
  // Stray clock pulses while deselected
  task automatic pulses(input int n);
    repeat (n) begin
      #32 sck = 1'b1;
      #32 sck = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// file: verification/adc_readout_chk.sv
// Checker of the readout block's port behaviour.
// Assumes binding to the core top module.
`default_nettype none
module adc_readout_chk #(parameter int CONV_CYCLES = 50) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs_n_pin,
  input wire logic serial_out_pin,
  input wire logic serial_out_oe,
  input wire logic sck_oe,
  input wire logic converting,
  input wire logic sleeping,
  input wire logic int_sck_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Counts cycles of the conversion state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      cnt_reg <= 0;
    else
      cnt_reg <= converting ? cnt_reg + 1 : 0;
  end
  // ****
  // Port rules
  // ****
  a_conv_len: assert property ($fell(converting) |-> cnt_reg == CONV_CYCLES)
    else $error("conversion length wrong");
  a_conv_to_sleep: assert property ($fell(converting) |-> ##[0:1] sleeping)
    else $error("no sleep after conversion");
  a_one_state: assert property (!(converting && sleeping))
    else $error("two states at once");
  a_sleep_holds: assert property (sleeping && cs_n_pin |=> sleeping && !converting)
    else $error("sleep left while deselected");
  a_oe_off: assert property (cs_n_pin [*5] |-> !serial_out_oe)
    else $error("output driven while deselected");
  a_oe_on: assert property ($fell(cs_n_pin) ##1 !cs_n_pin [*4] |-> serial_out_oe)
    else $error("output not driven when selected");
  a_pend_low: assert property (sleeping && serial_out_oe |-> !serial_out_pin)
    else $error("pending flag high in sleep");
  a_pend_high: assert property (converting && serial_out_oe && !cs_n_pin ##1 converting
    |-> $past(serial_out_pin))
    else $error("pending flag low in conversion");
  a_ext_clock: assert property (!int_sck_mode |-> !sck_oe)
    else $error("clock driven in external mode");
  c_frame_end: cover property (!cs_n_pin && $rose(converting));
  c_abort: cover property (cs_n_pin && $rose(converting));
  c_wake: cover property (sleeping && serial_out_oe);
endmodule
bind adc_cycle_serial_readout adc_readout_chk #(.CONV_CYCLES(CONV_CYCLES)) u_chk (
  .clk(clk), .rst_n(rst_n), .cs_n_pin(cs_n_pin), .serial_out_pin(serial_out_pin),
  .serial_out_oe(serial_out_oe), .sck_oe(sck_oe), .converting(converting),
  .sleeping(sleeping), .int_sck_mode(int_sck_mode));
`default_nettype wire

// file: verification/testbench.sv
// Testbench of the converter cycle and serial readout block.
// Assumes the host model and the checker are compiled before it.
`default_nettype none
`include "adc_readout_map.svh"
module testbench;
  import adc_readout_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic signed [`RAW_BITS-1:0] raw_result = '0;
  logic cs_n, host_sck, so_pin, so_oe, sck_out, sck_oe, conv, slp, mode;
  wire logic sdo_w, sck_w;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [31:0] bits;
  always #25 clk = ~clk;
  // Pin resolution; a released data line shows no stale level
  assign sdo_w = so_oe ? so_pin : ~so_pin;
  assign sck_w = sck_oe ? sck_out : host_sck;
  adc_host_model i_adc_host_model (.clk(clk), .sdo_pin(sdo_w), .sck_pin(sck_w), .cs_n(cs_n),
    .sck(host_sck));
  adc_cycle_serial_readout #(.POR_CYCLES(20), .CONV_CYCLES(50)) i_adc_cycle_serial_readout (
    .clk(clk), .rst_n(rst_n), .link_sck(sck_w), .cs_n_pin(cs_n), .raw_result(raw_result),
    .serial_out_pin(so_pin), .serial_out_oe(so_oe), .sck_out(sck_out), .sck_oe(sck_oe),
    .converting(conv), .sleeping(slp), .int_sck_mode(mode));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask
  task automatic conclude();
    if (n_mismatch == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Bounded wait for the sleep state
  task automatic wait_sleep();
    int i;
    i = 0;
    while (slp !== 1'b1 && i < 500) begin
      @(posedge clk);
      #2;
      i++;
    end
    chk("sleep reached", 32'h1, slp);
  endtask
  // Expected frame: clamp, offset, status and tail bits
  function automatic logic [23:0] exp_frame(input int raw);
    int c;
    c = raw > 65536 ? 65536 : (raw < -65537 ? -65537 : raw);
    c = c + 131072;
    return {2'b00, c[17:0], 4'h0};
  endfunction
  // Every result class through a 32-clock read
  task automatic t_codes();
    int vals[8] = '{0, -1, 65535, 65536, 70000, -65536, -65537, -80000};
    foreach (vals[i]) begin
      wait_sleep();
      raw_result = vals[i][18:0];
      i_adc_host_model.frame(24, 1'b1, bits);
      wait_sleep();
      i_adc_host_model.frame(32, 1'b1, bits);
      chk("frame", {exp_frame(vals[i]), 8'hFF}, bits);
    end
  endtask
  // Select kept low over frame end, then early release
  task automatic t_pending();
    wait_sleep();
    i_adc_host_model.frame(24, 1'b0, bits);
    repeat (4) @(posedge clk);
    #2 chk("busy flag", 32'h3, {conv, sdo_w});
    wait_sleep();
    chk("done flag", 32'h0, sdo_w);
    i_adc_host_model.frame(0, 1'b1, bits);
    repeat (8) @(posedge clk);
    #2 chk("back to sleep", 32'h1, {conv, slp});
    // New input while asleep; restored before the next conversion ends
    raw_result = 19'h00100;
    i_adc_host_model.frame(24, 1'b1, bits);
    raw_result = 19'h6C780;
    chk("kept result", exp_frame(-80000), bits);
  endtask
  // Clock pulses while deselected leave result and state alone
  task automatic t_float();
    wait_sleep();
    chk("float", 32'h0, so_oe);
    i_adc_host_model.pulses(6);
    repeat (4) @(posedge clk);
    #2 chk("still asleep", 32'h1, slp);
    i_adc_host_model.frame(24, 1'b1, bits);
    chk("after pulses", exp_frame(-80000), bits);
  endtask
  // Release after five clocks starts a conversion
  task automatic t_abort();
    wait_sleep();
    i_adc_host_model.frame(5, 1'b1, bits);
    chk("first bits", exp_frame(-80000) >> 19, bits);
    repeat (6) @(posedge clk);
    #2 chk("abort converts", 32'h1, conv);
    wait_sleep();
    i_adc_host_model.frame(24, 1'b1, bits);
    chk("next result", exp_frame(-80000), bits);
  endtask
  // Device drives the clock after a high strap at select fall
  task automatic t_internal();
    wait_sleep();
    i_adc_host_model.frame_int(bits);
    chk("internal frame", exp_frame(-80000), bits);
    chk("internal mode", 32'h1, mode);
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    #2 rst_n = 1'b1;
    chk("power-on idle", 32'h0, {conv, slp});
    wait_sleep();
    chk("clock mode", 32'h0, {mode, sck_oe});
    t_codes();
    t_pending();
    t_float();
    t_abort();
    t_internal();
    conclude();
  end
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      conclude();
    end
  end
endmodule
`default_nettype wire
